//--- common/dma_channel_config_defs.vh
// constants for the dma channel configuration block
`ifndef DMA_CHANNEL_CONFIG_DEFS_VH
`define DMA_CHANNEL_CONFIG_DEFS_VH
// ====================================================================
// sfr addresses
`define SEL_REG_ADDR     8'h94
`define CFG_REG_ADDR     8'hd8
`define BUSY_REG_ADDR    8'h93
// ====================================================================
// reset values
`define SEL_RESET        3'h0
`define CFG_RESET        8'h00
`define BUSY_RESET       7'h00
// ====================================================================
// config fields
`define CFG_FULL_EN_BIT  7
`define CFG_MID_EN_BIT   6
`define CFG_STALL_BIT    5
`define CFG_ENDIAN_BIT   4
`define CFG_RSVD_BIT     3
`define CFG_FUNC_HI      2
`define CFG_FUNC_LO      0
`define CFG_WR_MASK      8'hf7
// ====================================================================
// channel select field
`define SEL_HI           2
`define SEL_LO           0
`define SEL_NONE         3'h7
// ====================================================================
// transfer function codes
`define FUNC_RSVD0       3'h0
`define FUNC_RSVD1       3'h1
`define FUNC_RAM_TO_A    3'h2
`define FUNC_RAM_TO_B    3'h3
`define FUNC_RAM_TO_ACC  3'h4
`define FUNC_ACC_TO_RAM  3'h5
`define FUNC_I2C_TO_RAM  3'h6
`define FUNC_RAM_TO_I2C  3'h7
// ====================================================================
// peripheral target codes
`define TGT_MAC_A        2'h0
`define TGT_MAC_B        2'h1
`define TGT_MAC_ACC      2'h2
`define TGT_I2C          2'h3
`endif

//--- hw/dma_cfg_bank.v
// banked per-channel configuration storage and channel select
`timescale 1ns/1ps
`include "dma_channel_config_defs.vh"
module dma_cfg_bank #(
    parameter NUM_CH = 7
) (
    input  wire                  i_clock,
    input  wire                  i_reset,
    input  wire                  i_sel_wr,
    input  wire                  i_cfg_wr,
    input  wire [7:0]            i_wdata,
    output wire [2:0]            o_sel,
    output wire [7:0]            o_cfg_sel,
    output wire [NUM_CH*8-1:0]   o_cfg_all
);
    reg  [2:0] sel_r;
    reg  [7:0] cfg_r [0:NUM_CH-1];
    integer    k;
    genvar     g;

    // ====================================================================
    // select and banked storage; select 7 reaches no bank
    always @(posedge i_clock) begin
        if (i_reset) begin
            sel_r <= `SEL_RESET;
            for (k = 0; k < NUM_CH; k = k + 1) begin
                cfg_r[k] <= `CFG_RESET;
            end
        end else begin
            if (i_sel_wr) begin
                sel_r <= i_wdata[`SEL_HI:`SEL_LO];
            end
            if (i_cfg_wr && sel_r != `SEL_NONE) begin
                // reserved bit never stores
                cfg_r[sel_r] <= i_wdata & `CFG_WR_MASK;
            end
        end
    end

    assign o_sel     = sel_r;
    // select 7 reads as reset value
    assign o_cfg_sel = (sel_r == `SEL_NONE) ? `CFG_RESET : cfg_r[sel_r];

    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : flat
            assign o_cfg_all[g*8 +: 8] = cfg_r[g];
        end
    endgenerate
endmodule

//--- hw/dma_byte_mover.v
// moves one byte between data ram and a peripheral
`timescale 1ns/1ps
`include "dma_channel_config_defs.vh"
module dma_byte_mover #(
    parameter AW = 12
) (
    input  wire          i_clock,
    input  wire          i_reset,
    input  wire          i_start,
    input  wire          i_to_ram,
    input  wire [1:0]    i_target,
    input  wire [2:0]    i_lane,
    input  wire [AW-1:0] i_addr,
    input  wire [7:0]    i_ram_rdata,
    input  wire          i_ram_ack,
    input  wire [7:0]    i_per_rdata,
    input  wire          i_per_ack,
    output reg           o_ram_rd,
    output reg           o_ram_wr,
    output reg  [AW-1:0] o_ram_addr,
    output reg  [7:0]    o_ram_wdata,
    output reg           o_per_rd,
    output reg           o_per_wr,
    output reg  [1:0]    o_per_target,
    output reg  [2:0]    o_per_lane,
    output reg  [7:0]    o_per_wdata,
    output reg           o_done
);
    localparam S_IDLE = 3'b001;
    localparam S_READ = 3'b010;
    localparam S_WRITE = 3'b100;
    reg  [2:0] state_r;
    reg        to_ram_r;

    // ====================================================================
    // read the source then write the destination; requests hold until ack
    always @(posedge i_clock) begin
        if (i_reset) begin
            state_r <= S_IDLE;
            to_ram_r <= 1'b0;
            o_ram_rd <= 1'b0;
            o_ram_wr <= 1'b0;
            o_ram_addr <= {AW{1'b0}};
            o_ram_wdata <= 8'h00;
            o_per_rd <= 1'b0;
            o_per_wr <= 1'b0;
            o_per_target <= `TGT_MAC_A;
            o_per_lane <= 3'h0;
            o_per_wdata <= 8'h00;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (i_start) begin
                        to_ram_r <= i_to_ram;
                        o_ram_addr <= i_addr;
                        o_per_target <= i_target;
                        o_per_lane <= i_lane;
                        o_per_rd <= i_to_ram;
                        o_ram_rd <= ~i_to_ram;
                        state_r <= S_READ;
                    end
                end
                S_READ: begin
                    if (to_ram_r && i_per_ack) begin
                        o_per_rd <= 1'b0;
                        o_ram_wdata <= i_per_rdata;
                        o_ram_wr <= 1'b1;
                        state_r <= S_WRITE;
                    end else if (!to_ram_r && i_ram_ack) begin
                        o_ram_rd <= 1'b0;
                        o_per_wdata <= i_ram_rdata;
                        o_per_wr <= 1'b1;
                        state_r <= S_WRITE;
                    end
                end
                S_WRITE: begin
                    if ((o_ram_wr && i_ram_ack) || (o_per_wr && i_per_ack)) begin
                        o_ram_wr <= 1'b0;
                        o_per_wr <= 1'b0;
                        o_done <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule

//--- hw/dma_channel_config.v
// seven channel dma configuration, arbitration and byte routing
//
// How it works
// - config bit 7 lets the selected channel's full-length interrupt out.
// - config bit 6 lets the selected channel's mid-point interrupt out.
// - stall bit 5 holds the channel; it starts no new byte moves.
// - a stalled channel keeps its progress and resumes once stall clears.
// - bit 4 chooses little (0) or big (1) endian data ram byte order.
// - bits 2:0 choose the data path; codes 000 and 001 are reserved.
// - code 010 moves ram to mac a, 011 moves ram to mac b.
// - code 100 moves ram to accumulator, 101 accumulator to ram.
// - code 110 moves i2c slave data to ram, 111 ram to i2c.
// - config register is banked; select register names the channel reached.
// - select bits 2:0 pick channels 0 to 6; 111 is reserved.
// - busy set while a channel transfers; writing 1 starts the channel.
`timescale 1ns/1ps
`include "dma_channel_config_defs.vh"
module dma_channel_config #(
    parameter NUM_CH    = 7,
    parameter XFER_LEN  = 8,
    parameter ACC_BYTES = 4,
    parameter AW        = 12
) (
    input  wire              i_clock,
    input  wire              i_reset,
    input  wire [7:0]        i_sfr_addr,
    input  wire              i_sfr_wr,
    input  wire              i_sfr_rd,
    input  wire [7:0]        i_sfr_wdata,
    output reg  [7:0]        o_sfr_rdata,
    output wire              o_ram_rd,
    output wire              o_ram_wr,
    output wire [AW-1:0]     o_ram_addr,
    output wire [7:0]        o_ram_wdata,
    input  wire [7:0]        i_ram_rdata,
    input  wire              i_ram_ack,
    output wire              o_per_rd,
    output wire              o_per_wr,
    output wire [1:0]        o_per_target,
    output wire [2:0]        o_per_lane,
    output wire [7:0]        o_per_wdata,
    input  wire [7:0]        i_per_rdata,
    input  wire              i_per_ack,
    output reg  [NUM_CH-1:0] o_busy,
    output reg  [2:0]        o_active_ch,
    output reg  [NUM_CH-1:0] o_full_irq,
    output reg  [NUM_CH-1:0] o_mid_irq
);
    // ====================================================================
    // local types and states
    localparam PW      = 8;
    localparam S_IDLE  = 3'b001;
    localparam S_MOVE  = 3'b010;
    localparam S_RSVD  = 3'b100;
    localparam [PW-1:0] LEN_C = XFER_LEN[PW-1:0];
    localparam [PW-1:0] MID_C = LEN_C >> 1;

    reg  [2:0]          state_r;
    reg  [NUM_CH-1:0]   busy_r;
    reg  [PW-1:0]       prog_r [0:NUM_CH-1];
    reg  [2:0]          act_r;
    reg                 start_r;
    reg                 to_ram_r;
    reg  [1:0]          target_r;
    reg  [2:0]          lane_r;
    reg  [AW-1:0]       addr_r;
    integer             k;

    wire [2:0]          sel;
    wire [7:0]          cfg_sel;
    wire [NUM_CH*8-1:0] cfg_all;
    wire                mover_done;
    wire                sel_wr;
    wire                cfg_wr;
    wire                busy_wr;
    wire [NUM_CH-1:0]   stall_v;
    wire [NUM_CH-1:0]   ready_v;
    wire [2:0]          pick;
    wire [7:0]          pick_cfg;
    wire [7:0]          act_cfg;
    wire [PW-1:0]       act_next;

    // ====================================================================
    // functions

    // lowest requesting channel, or the reserved code
    function [2:0] first_ch;
        input [NUM_CH-1:0] req;
        integer i;
        begin
            first_ch = `SEL_NONE;
            for (i = NUM_CH - 1; i >= 0; i = i - 1) begin
                if (req[i]) begin
                    first_ch = i[2:0];
                end
            end
        end
    endfunction

    // bytes per word of the target register
    function [2:0] word_bytes;
        input [2:0] func;
        begin
            case (func)
                `FUNC_RAM_TO_A:   word_bytes = 3'd2;
                `FUNC_RAM_TO_B:   word_bytes = 3'd2;
                `FUNC_RAM_TO_ACC: word_bytes = ACC_BYTES[2:0];
                `FUNC_ACC_TO_RAM: word_bytes = ACC_BYTES[2:0];
                default:          word_bytes = 3'd1;
            endcase
        end
    endfunction

    // byte lane for a byte index and byte order
    function [2:0] lane_of;
        input [PW-1:0] idx;
        input [2:0]    width;
        input          big;
        reg   [PW-1:0] pos;
        begin
            pos = idx % {{(PW-3){1'b0}}, width};
            if (big) begin
                lane_of = width - 3'd1 - pos[2:0];
            end else begin
                lane_of = pos[2:0];
            end
        end
    endfunction

    // peripheral register reached by a function code
    function [1:0] target_of;
        input [2:0] func;
        begin
            case (func)
                `FUNC_RAM_TO_A:   target_of = `TGT_MAC_A;
                `FUNC_RAM_TO_B:   target_of = `TGT_MAC_B;
                `FUNC_RAM_TO_ACC: target_of = `TGT_MAC_ACC;
                `FUNC_ACC_TO_RAM: target_of = `TGT_MAC_ACC;
                default:          target_of = `TGT_I2C;
            endcase
        end
    endfunction

    // ====================================================================
    // register decode
    assign sel_wr  = i_sfr_wr && (i_sfr_addr == `SEL_REG_ADDR);
    assign cfg_wr  = i_sfr_wr && (i_sfr_addr == `CFG_REG_ADDR);
    assign busy_wr = i_sfr_wr && (i_sfr_addr == `BUSY_REG_ADDR);

    dma_cfg_bank #(
        .NUM_CH     (NUM_CH)
    ) u_bank (
        .i_clock    (i_clock),
        .i_reset    (i_reset),
        .i_sel_wr   (sel_wr),
        .i_cfg_wr   (cfg_wr),
        .i_wdata    (i_sfr_wdata),
        .o_sel      (sel),
        .o_cfg_sel  (cfg_sel),
        .o_cfg_all  (cfg_all)
    );

    // ====================================================================
    // arbitration skips stalled channels
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : stl
            assign stall_v[g] = cfg_all[g*8 + `CFG_STALL_BIT];
        end
    endgenerate
    assign ready_v  = busy_r & ~stall_v;
    assign pick     = first_ch(ready_v);
    assign pick_cfg = cfg_all[pick*8 +: 8];
    assign act_cfg  = cfg_all[act_r*8 +: 8];
    assign act_next = prog_r[act_r] + 8'd1;

    // ====================================================================
    // sfr read data; reserved bits read zero
    always @(posedge i_clock) begin
        if (i_reset) begin
            o_sfr_rdata <= 8'h00;
        end else if (i_sfr_rd) begin
            case (i_sfr_addr)
                `SEL_REG_ADDR:  o_sfr_rdata <= {5'h00, sel};
                `CFG_REG_ADDR:  o_sfr_rdata <= cfg_sel;
                `BUSY_REG_ADDR: o_sfr_rdata <= {1'b0, busy_r};
                default:        o_sfr_rdata <= 8'h00;
            endcase
        end
    end

    // ====================================================================
    // sequencer: one byte per grant, then re-arbitrate;
    // idling between bytes lets a stall land on a byte
    // boundary with progress kept.
    always @(posedge i_clock) begin
        if (i_reset) begin
            state_r <= S_IDLE;
            busy_r <= `BUSY_RESET;
            act_r <= 3'h0;
            start_r <= 1'b0;
            to_ram_r <= 1'b0;
            target_r <= `TGT_MAC_A;
            lane_r <= 3'h0;
            addr_r <= {AW{1'b0}};
            o_full_irq <= {NUM_CH{1'b0}};
            o_mid_irq <= {NUM_CH{1'b0}};
            for (k = 0; k < NUM_CH; k = k + 1) begin
                prog_r[k] <= {PW{1'b0}};
            end
        end else begin
            start_r <= 1'b0;
            o_full_irq <= {NUM_CH{1'b0}};
            o_mid_irq <= {NUM_CH{1'b0}};
            case (state_r)
                S_IDLE: begin
                    if (pick != `SEL_NONE) begin
                        act_r <= pick;
                        if (pick_cfg[`CFG_FUNC_HI:`CFG_FUNC_LO]
                                <= `FUNC_RSVD1) begin
                            state_r <= S_RSVD;
                        end else begin
                            start_r <= 1'b1;
                            to_ram_r <= (pick_cfg[2:0] == `FUNC_ACC_TO_RAM)
                                || (pick_cfg[2:0] == `FUNC_I2C_TO_RAM);
                            target_r <= target_of(pick_cfg[2:0]);
                            lane_r <= lane_of(prog_r[pick],
                                word_bytes(pick_cfg[2:0]),
                                pick_cfg[`CFG_ENDIAN_BIT]);
                            addr_r <= {{(AW-PW){1'b0}}, prog_r[pick]};
                            state_r <= S_MOVE;
                        end
                    end
                end
                S_MOVE: begin
                    if (mover_done) begin
                        if (act_next == MID_C) begin
                            o_mid_irq[act_r] <= act_cfg[`CFG_MID_EN_BIT];
                        end
                        if (act_next == LEN_C) begin
                            prog_r[act_r] <= {PW{1'b0}};
                            busy_r[act_r] <= 1'b0;
                            o_full_irq[act_r] <= act_cfg[`CFG_FULL_EN_BIT];
                        end else begin
                            prog_r[act_r] <= act_next;
                        end
                        state_r <= S_IDLE;
                    end
                end
                S_RSVD: begin
                    // reserved path: end the transfer without moving data
                    busy_r[act_r] <= 1'b0;
                    state_r <= S_IDLE;
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
            // a start bit wins over its clear; other clears still land
            for (k = 0; k < NUM_CH; k = k + 1) begin
                if (busy_wr && i_sfr_wdata[k]) begin
                    busy_r[k] <= 1'b1;
                end
            end
        end
    end

    // ====================================================================
    // status outputs, one cycle late
    always @(posedge i_clock) begin
        if (i_reset) begin
            o_busy <= {NUM_CH{1'b0}};
            o_active_ch <= `SEL_NONE;
        end else begin
            o_busy <= busy_r;
            o_active_ch <= (state_r == S_MOVE) ? act_r : `SEL_NONE;
        end
    end

    // ====================================================================
    // byte mover; its outputs are flops
    dma_byte_mover #(
        .AW           (AW)
    ) u_mover (
        .i_clock      (i_clock),
        .i_reset      (i_reset),
        .i_start      (start_r),
        .i_to_ram     (to_ram_r),
        .i_target     (target_r),
        .i_lane       (lane_r),
        .i_addr       (addr_r),
        .i_ram_rdata  (i_ram_rdata),
        .i_ram_ack    (i_ram_ack),
        .i_per_rdata  (i_per_rdata),
        .i_per_ack    (i_per_ack),
        .o_ram_rd     (o_ram_rd),
        .o_ram_wr     (o_ram_wr),
        .o_ram_addr   (o_ram_addr),
        .o_ram_wdata  (o_ram_wdata),
        .o_per_rd     (o_per_rd),
        .o_per_wr     (o_per_wr),
        .o_per_target (o_per_target),
        .o_per_lane   (o_per_lane),
        .o_per_wdata  (o_per_wdata),
        .o_done       (mover_done)
    );
endmodule

//--- bench/dma_channel_config_checker.sv
// assertions for the dma channel config block
`timescale 1ns/1ps
`include "dma_channel_config_defs.vh"
module dma_channel_config_checker #(
    parameter NUM_CH = 7
) (
    input wire              i_clock,
    input wire              i_reset,
    input wire [7:0]        i_sfr_addr,
    input wire              i_sfr_wr,
    input wire              i_sfr_rd,
    input wire [7:0]        i_sfr_wdata,
    input wire [7:0]        o_sfr_rdata,
    input wire              o_ram_rd,
    input wire              o_ram_wr,
    input wire              i_ram_ack,
    input wire              o_per_rd,
    input wire              o_per_wr,
    input wire [7:0]        o_per_wdata,
    input wire              i_per_ack,
    input wire [NUM_CH-1:0] o_busy,
    input wire [NUM_CH-1:0] o_full_irq,
    input wire [NUM_CH-1:0] o_mid_irq
);
    reg  [2:0]        sel_r;
    wire              wr_cfg = i_sfr_wr && i_sfr_addr == `CFG_REG_ADDR;
    wire              rd_cfg = i_sfr_rd && i_sfr_addr == `CFG_REG_ADDR;
    wire [NUM_CH-1:0] irq = o_full_irq | o_mid_irq;
    // ==================
    // select shadow
    always @(posedge i_clock) begin
        if (i_reset)
            sel_r <= 3'h0;
        else if (i_sfr_wr && i_sfr_addr == `SEL_REG_ADDR)
            sel_r <= i_sfr_wdata[2:0];
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    property p_cfg_rsvd;
        rd_cfg |=> !o_sfr_rdata[`CFG_RSVD_BIT];
    endproperty
    a_cfg_rsvd: assert property (p_cfg_rsvd)
        else $error("rsvd bit set");
    property p_cfg_bank;
        wr_cfg && sel_r != `SEL_NONE ##1 !i_sfr_wr ##1 rd_cfg |=>
            o_sfr_rdata == ($past(i_sfr_wdata, 3) & `CFG_WR_MASK);
    endproperty
    a_cfg_bank: assert property (p_cfg_bank)
        else $error("bank readback");
    property p_sel_none;
        rd_cfg && sel_r == `SEL_NONE |=> o_sfr_rdata == `CFG_RESET;
    endproperty
    a_sel_none: assert property (p_sel_none)
        else $error("rsvd select read");
    property p_busy_start;
        i_sfr_wr && i_sfr_addr == `BUSY_REG_ADDR && i_sfr_wdata[0]
            |-> ##[1:3] o_busy[0];
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("busy not set");
    property p_ram_hold;
        o_ram_rd && !i_ram_ack |=> o_ram_rd;
    endproperty
    a_ram_hold: assert property (p_ram_hold)
        else $error("ram read dropped");
    property p_per_hold;
        o_per_wr && !i_per_ack |=> o_per_wr && $stable(o_per_wdata);
    endproperty
    a_per_hold: assert property (p_per_hold)
        else $error("per write changed");
    property p_one_req;
        $onehot0({o_ram_rd, o_ram_wr, o_per_rd, o_per_wr});
    endproperty
    a_one_req: assert property (p_one_req)
        else $error("two requests");
    property p_irq_busy;
        irq != 0 |-> (irq & ~(o_busy | $past(o_busy))) == 0;
    endproperty
    a_irq_busy: assert property (p_irq_busy)
        else $error("irq when idle");
    c_mid: cover property (o_mid_irq != 0);
    c_full: cover property (o_full_irq != 0);
    c_per_wr: cover property (o_per_wr && i_per_ack);
endmodule
bind dma_channel_config dma_channel_config_checker #(.NUM_CH(NUM_CH))
    chk_u (.*);

//--- bench/dma_far_side_model.sv
// far side model: data ram and peripheral registers
`timescale 1ns/1ps
module dma_far_side_model (
    input  wire        i_clock,
    input  wire        i_reset,
    input  wire        i_slow,
    input  wire        i_ram_rd,
    input  wire        i_ram_wr,
    input  wire [11:0] i_ram_addr,
    input  wire [7:0]  i_ram_wdata,
    input  wire        i_per_rd,
    input  wire        i_per_wr,
    input  wire [4:0]  i_per_pos,
    input  wire [7:0]  i_per_wdata,
    output reg  [7:0]  o_rdata,
    output reg         o_ram_ack,
    output reg         o_per_ack,
    output reg  [7:0]  o_wr_cnt,
    output reg  [4:0]  o_last_pos,
    output reg  [7:0]  o_last_data
);
    reg  [2:0] wait_r;
    wire       req = i_ram_rd | i_ram_wr | i_per_rd | i_per_wr;
    // one ack per request after 0 or 6 waits; data toggles off ack
    always @(posedge i_clock) begin
        o_ram_ack <= 1'b0;
        o_per_ack <= 1'b0;
        o_rdata   <= ~o_rdata;
        if (i_reset) begin
            wait_r   <= 3'h0;
            o_rdata  <= 8'h00;
            o_wr_cnt <= 8'h00;
        end else if (o_ram_ack | o_per_ack | !req) begin
            wait_r <= 3'h0;
        end else if (i_slow && wait_r != 3'h6) begin
            wait_r <= wait_r + 3'h1;
        end else begin
            o_ram_ack <= i_ram_rd | i_ram_wr;
            o_per_ack <= i_per_rd | i_per_wr;
            o_rdata   <= i_ram_rd ? {5'h02, i_ram_addr[2:0]}
                                  : {3'h5, i_per_pos};
            o_wr_cnt  <= o_wr_cnt + {7'h00, i_ram_wr | i_per_wr};
            if (i_ram_wr | i_per_wr) begin
                o_last_pos  <= i_ram_wr ? {2'h0, i_ram_addr[2:0]} : i_per_pos;
                o_last_data <= i_ram_wr ? i_ram_wdata : i_per_wdata;
            end
        end
    end
endmodule

//--- bench/testbench.sv
// testbench for the dma channel config block
`timescale 1ns/1ps
`include "dma_channel_config_defs.vh"
module testbench;
    reg         i_clock = 1'b0, i_reset = 1'b1, slow = 1'b0;
    reg         i_sfr_wr = 1'b0, i_sfr_rd = 1'b0;
    reg  [7:0]  i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00;
    reg  [7:0]  full_n = 8'h00, mid_n = 8'h00, base, f0, m0;
    reg  [2:0]  cur_ch = 3'h0, c, lane;
    reg  [1:0]  tgt;
    reg         to_ram;
    integer     miscompares = 0, check_count = 0, f, k, n;
    wire [7:0]  o_sfr_rdata, o_ram_wdata, o_per_wdata, rdata, wr_cnt;
    wire [7:0]  last_data;
    wire [11:0] o_ram_addr;
    wire [6:0]  o_busy, o_full_irq, o_mid_irq;
    wire [4:0]  last_pos;
    wire [2:0]  o_per_lane, act;
    wire [1:0]  o_per_target;
    wire        o_ram_rd, o_ram_wr, i_ram_ack, o_per_rd, o_per_wr, i_per_ack;
    dma_channel_config dut_u (.*, .i_ram_rdata(rdata), .i_per_rdata(rdata),
        .o_active_ch(act));
    dma_far_side_model far_u (.i_clock(i_clock), .i_reset(i_reset),
        .i_slow(slow), .i_ram_rd(o_ram_rd), .i_ram_wr(o_ram_wr),
        .i_ram_addr(o_ram_addr), .i_ram_wdata(o_ram_wdata),
        .i_per_rd(o_per_rd), .i_per_wr(o_per_wr),
        .i_per_pos({o_per_target, o_per_lane}), .i_per_wdata(o_per_wdata),
        .o_rdata(rdata), .o_ram_ack(i_ram_ack), .o_per_ack(i_per_ack),
        .o_wr_cnt(wr_cnt), .o_last_pos(last_pos), .o_last_data(last_data));
    // ==================
    // clock and irq pulse counters
    initial begin
        forever #4 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        full_n <= full_n + {7'h00, o_full_irq[cur_ch]};
        mid_n  <= mid_n + {7'h00, o_mid_irq[cur_ch]};
    end
    task check(input [7:0] seen, input [7:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("unexpected at %0t: %h vs %h", $time, seen, exp);
            end
        end
    endtask
    task wrap_up;
        begin
            if (miscompares == 0 && check_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // ==================
    // sfr strobes last one cycle, then one idle cycle
    task sfr_wr(input [7:0] a, input [7:0] d);
        begin
            i_sfr_addr  <= a;
            i_sfr_wdata <= d;
            i_sfr_wr    <= 1'b1;
            @(posedge i_clock);
            i_sfr_wr    <= 1'b0;
            @(posedge i_clock);
        end
    endtask
    task rd_chk(input [7:0] a, input [7:0] e);
        begin
            i_sfr_addr <= a;
            i_sfr_rd   <= 1'b1;
            @(posedge i_clock);
            i_sfr_rd   <= 1'b0;
            @(posedge i_clock);
            check(o_sfr_rdata, e);
        end
    endtask
    // bounded wait; a hang is caught by the busy check
    task wait_idle;
        begin
            repeat (4) @(posedge i_clock);
            n = 0;
            while (o_busy !== 7'h00 && n < 4000) begin
                @(posedge i_clock);
                n = n + 1;
            end
            repeat (4) @(posedge i_clock);
        end
    endtask
    task run(input [2:0] ch, input [7:0] cfg);
        begin
            cur_ch = ch;
            sfr_wr(`SEL_REG_ADDR, {5'h00, ch});
            sfr_wr(`CFG_REG_ADDR, cfg);
            base = wr_cnt;
            f0 = full_n;
            m0 = mid_n;
            sfr_wr(`BUSY_REG_ADDR, 8'h01 << ch);
            wait_idle;
            check({1'b0, o_busy}, 8'h00);
        end
    endtask
    // ==================
    // main sequence
    initial begin
        repeat (4) @(posedge i_clock);
        i_reset <= 1'b0;
        @(posedge i_clock);
        rd_chk(`SEL_REG_ADDR, 8'h00);
        rd_chk(`CFG_REG_ADDR, 8'h00);
        rd_chk(`BUSY_REG_ADDR, 8'h00);
        sfr_wr(`SEL_REG_ADDR, 8'h02);
        sfr_wr(`CFG_REG_ADDR, 8'h52);
        sfr_wr(`SEL_REG_ADDR, 8'h01);
        sfr_wr(`CFG_REG_ADDR, 8'hf7);
        rd_chk(`CFG_REG_ADDR, 8'hf7);
        sfr_wr(`SEL_REG_ADDR, 8'h02);
        rd_chk(`CFG_REG_ADDR, 8'h52);
        sfr_wr(`SEL_REG_ADDR, 8'h07);
        sfr_wr(`CFG_REG_ADDR, 8'hf7);
        rd_chk(`CFG_REG_ADDR, 8'h00);
        // all function codes, both byte orders; even codes fast, odd codes slow
        for (f = 0; f < 16; f = f + 1) begin
            c = f[3:1];
            slow <= f[1];
            run(3'h0, {3'h6, f[0], 1'b0, c});
            tgt = c[2] ? {1'b1, c[1]} : {1'b0, c[0]};
            lane = f[0] ? 3'h0 : (c[2] ? (c[1] ? 3'h0 : 3'h3) : 3'h1);
            to_ram = (c == 3'h5) || (c == 3'h6);
            if (c < 3'h2) begin
                check(wr_cnt - base, 8'h00);
                check(full_n - f0, 8'h00);
            end else begin
                check(wr_cnt - base, 8'h08);
                check({3'h0, last_pos}, to_ram ? 8'h07 : {tgt, lane});
                check(last_data, to_ram ? {3'h5, tgt, lane} : 8'h17);
                check(full_n - f0, 8'h01);
                check(mid_n - m0, 8'h01);
            end
        end
        // each enable pairing on its own channel
        for (k = 0; k < 4; k = k + 1) begin
            run(k[2:0] + 3'h3, {k[1:0], 6'h03});
            check(full_n - f0, {7'h00, k[1]});
            check(mid_n - m0, {7'h00, k[0]});
        end
        // stall in mid transfer, then resume
        slow <= 1'b1;
        sfr_wr(`SEL_REG_ADDR, 8'h05);
        sfr_wr(`CFG_REG_ADDR, 8'h02);
        base = wr_cnt;
        sfr_wr(`BUSY_REG_ADDR, 8'h20);
        repeat (60) @(posedge i_clock);
        sfr_wr(`CFG_REG_ADDR, 8'h22);
        repeat (20) @(posedge i_clock);
        f0 = wr_cnt;
        repeat (100) @(posedge i_clock);
        check(wr_cnt, f0);
        check({1'b0, o_busy}, 8'h20);
        check({5'h00, act}, 8'h07);
        sfr_wr(`CFG_REG_ADDR, 8'h02);
        wait_idle;
        check(wr_cnt - base, 8'h08);
        check({3'h0, last_pos}, 8'h01);
        wrap_up;
    end
    // watchdog far beyond the few thousand cycles needed
    initial begin
        #400000;
        miscompares = miscompares + 1;
        wrap_up;
    end
endmodule
